// ===== sdt_regs.svh
// register offsets, instruction field positions and reset values for the transfer unit
`ifndef SDT_REGS_SVH
`define SDT_REGS_SVH

// ==========================================================
// wishbone register map (byte addresses)
`define SDT_OFS_CTRL      8'h00
`define SDT_OFS_STATUS    8'h04
`define SDT_OFS_DONE_CNT  8'h08
`define SDT_OFS_SKIP_CNT  8'h0c
`define SDT_OFS_LAST_ADDR 8'h10

// ==========================================================
// register fields and reset values
`define SDT_CTRL_EN_BIT    0
`define SDT_CTRL_RESET     32'h0000_0001
`define SDT_STATUS_BUSY    0
`define SDT_STATUS_WAIT    1

// ==========================================================
// instruction fields
`define SDT_F_COND_HI 31
`define SDT_F_COND_LO 28
`define SDT_F_I       25
`define SDT_F_P       24
`define SDT_F_U       23
`define SDT_F_B       22
`define SDT_F_W       21
`define SDT_F_L       20
`define SDT_F_RN_HI   19
`define SDT_F_RN_LO   16
`define SDT_F_RD_HI   15
`define SDT_F_RD_LO   12
`define SDT_F_IMM_HI  11
`define SDT_F_SAMT_HI 11
`define SDT_F_SAMT_LO 7
`define SDT_F_STYP_HI 6
`define SDT_F_STYP_LO 5

// flag positions within flags_i
`define SDT_FLAG_N 3
`define SDT_FLAG_Z 2
`define SDT_FLAG_C 1
`define SDT_FLAG_V 0

`endif

// ===== sdt_pkg.sv
// types shared by the transfer unit
package sdt_pkg;

	typedef enum logic [1:0] {
		SDT_IDLE = 2'b00,
		SDT_MEM  = 2'b01,
		SDT_DONE = 2'b10
	} sdt_state_t;

	typedef enum logic [1:0] {
		SDT_LSL = 2'b00,
		SDT_LSR = 2'b01,
		SDT_ASR = 2'b10,
		SDT_ROR = 2'b11
	} sdt_shift_t;

endpackage

// ===== sdt_lane.sv
// byte lane steering: load extraction/rotation and store replication
module sdt_lane
	import sdt_pkg::*;
(
	input  wire logic        big_i,   // big-endian lane order
	input  wire logic        byte_i,  // byte transfer
	input  wire logic [1:0]  sel_i,   // address bits 1:0
	input  wire logic [31:0] rdata_i, // word from the data bus
	input  wire logic [31:0] src_i,   // store source register
	output logic      [31:0] load_o,  // value for the destination register
	output logic      [31:0] store_o  // word driven on the data bus
);

	logic [1:0]  lane;
	logic [4:0]  rot;
	logic [63:0] dbl;

	always_comb begin
		// big-endian counts lanes downward from bits 31:24
		lane = big_i ? ~sel_i : sel_i;
		rot  = {sel_i, 3'b000};
		dbl  = {rdata_i, rdata_i} >> rot;
		if (byte_i) begin
			load_o = {24'h00_0000, rdata_i[8*lane +: 8]};
			store_o = {4{src_i[7:0]}};
		end else begin
			// one rotation for both orders: the addressed byte ends in 7:0 only for little-endian
			load_o = dbl[31:0];
			store_o = src_i;
		end
	end

endmodule

// ===== sdt_core.sv
// single data transfer unit: address generation, indexing, lane steering, wishbone control
`include "sdt_regs.svh"

module sdt_core
	import sdt_pkg::*;
(
	input  wire logic        clk_i,              // core clock
	input  wire logic        arst_n_i,           // async reset, active low
	input  wire logic        wb_cyc_i,           // wishbone cycle
	input  wire logic        wb_stb_i,           // wishbone strobe
	input  wire logic        wb_we_i,            // wishbone write
	input  wire logic [7:0]  wb_adr_i,           // wishbone byte address
	input  wire logic [3:0]  wb_sel_i,           // wishbone byte select
	input  wire logic [31:0] wb_dat_i,           // wishbone write data
	output logic      [31:0] wb_dat_o,           // wishbone read data
	output logic             wb_ack_o,           // wishbone acknowledge
	input  wire logic        instr_valid_i,      // instruction offered
	output logic             instr_ready_o,      // instruction taken when valid
	input  wire logic [31:0] instr_i,            // instruction word
	input  wire logic [3:0]  flags_i,            // n z c v
	input  wire logic [31:0] base_register_i,    // base register value
	input  wire logic [31:0] offset_reg_i,       // offset register value
	input  wire logic [31:0] src_reg_i,          // store source value
	input  wire logic        endianness_select_i, // high: big-endian
	output logic             mem_req_o,          // memory request, held to ack
	output logic [31:0]      mem_addr_o,         // transfer address
	output logic             mem_we_o,           // store
	output logic             mem_byte_o,         // byte transfer
	output logic             mem_user_o,         // non-privileged access
	output logic [31:0]      mem_wdata_o,        // store data
	input  wire logic [31:0] mem_rdata_i,        // load data
	input  wire logic        mem_ack_i,          // memory done
	output logic             rd_we_o,            // destination write pulse
	output logic [3:0]       rd_idx_o,           // destination index
	output logic [31:0]      rd_data_o,          // destination value
	output logic             base_we_o,          // base write-back pulse
	output logic [3:0]       base_idx_o,         // base index
	output logic [31:0]      base_data_o,        // modified base
	output logic             skip_o              // condition failed pulse
);

	// ==========================================================
	// decode helpers
	function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
		logic n, z, cy, v;
		n  = f[`SDT_FLAG_N];
		z  = f[`SDT_FLAG_Z];
		cy = f[`SDT_FLAG_C];
		v  = f[`SDT_FLAG_V];
		case (c)
			4'h0: cond_pass = z;
			4'h1: cond_pass = !z;
			4'h2: cond_pass = cy;
			4'h3: cond_pass = !cy;
			4'h4: cond_pass = n;
			4'h5: cond_pass = !n;
			4'h6: cond_pass = v;
			4'h7: cond_pass = !v;
			4'h8: cond_pass = cy && !z;
			4'h9: cond_pass = !cy || z;
			4'ha: cond_pass = n == v;
			4'hb: cond_pass = n != v;
			4'hc: cond_pass = !z && (n == v);
			4'hd: cond_pass = z || (n != v);
			4'he: cond_pass = 1'b1;
			default: cond_pass = 1'b0;
		endcase
	endfunction

	// immediate-amount shifter; amount zero encodes the 32-place and rrx forms
	function automatic logic [31:0] shift_imm(input logic [31:0] val, input sdt_shift_t typ,
			input logic [4:0] amt, input logic cin);
		logic [63:0] rr;
		rr = {val, val} >> amt;
		case (typ)
			SDT_LSL: shift_imm = val << amt;
			SDT_LSR: shift_imm = (amt == 5'h00) ? 32'h0000_0000 : (val >> amt);
			SDT_ASR: shift_imm = (amt == 5'h00) ? {32{val[31]}} : 32'($signed(val) >>> amt);
			SDT_ROR: shift_imm = (amt == 5'h00) ? {cin, val[31:1]} : rr[31:0];
			default: shift_imm = val;
		endcase
	endfunction

	// ==========================================================
	// wishbone registers
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] done_cnt, next_done_cnt;
	logic [31:0] skip_cnt, next_skip_cnt;
	logic [31:0] last_addr, next_last_addr;
	logic [31:0] next_wb_dat;
	logic        next_wb_ack;
	logic        wb_hit;

	// ==========================================================
	// transfer state
	sdt_state_t  state, next_state;
	logic [31:0] ins, next_ins;
	logic [31:0] addr, next_addr;
	logic [31:0] modaddr, next_modaddr;
	logic [31:0] src, next_src;
	logic [31:0] rdata, next_rdata;
	logic        skip, next_skip;
	logic [31:0] offset;
	logic [31:0] modified;
	logic [31:0] lane_load;
	logic [31:0] lane_store;
	logic        take;

	sdt_lane u_lane (
		.big_i   (endianness_select_i),
		.byte_i  (ins[`SDT_F_B]),
		.sel_i   (addr[1:0]),
		.rdata_i (rdata),
		.src_i   (src),
		.load_o  (lane_load),
		.store_o (lane_store)
	);

	assign instr_ready_o = (state == SDT_IDLE) && ctrl[`SDT_CTRL_EN_BIT];
	assign take          = instr_valid_i && instr_ready_o;

	always_comb begin
		// register offset only takes the immediate shift amount
		if (instr_i[`SDT_F_I]) begin
			offset = shift_imm(offset_reg_i, sdt_shift_t'(instr_i[`SDT_F_STYP_HI:`SDT_F_STYP_LO]),
				instr_i[`SDT_F_SAMT_HI:`SDT_F_SAMT_LO], flags_i[`SDT_FLAG_C]);
		end else begin
			offset = {20'h0_0000, instr_i[`SDT_F_IMM_HI:0]};
		end
		modified = instr_i[`SDT_F_U] ? base_register_i + offset
			: base_register_i - offset;
	end

	always_comb begin
		next_state   = state;
		next_ins     = ins;
		next_addr    = addr;
		next_modaddr = modaddr;
		next_src     = src;
		next_rdata   = rdata;
		next_skip    = 1'b0;
		case (state)
			SDT_IDLE: begin
				if (take) begin
					next_ins = instr_i;
					if (cond_pass(instr_i[`SDT_F_COND_HI:`SDT_F_COND_LO], flags_i)) begin
						next_addr    = instr_i[`SDT_F_P] ? modified : base_register_i;
						next_modaddr = modified;
						next_src     = src_reg_i;
						next_state   = SDT_MEM;
					end else begin
						next_skip = 1'b1;
					end
				end
			end
			SDT_MEM: begin
				// request stays up until the memory answers
				if (mem_ack_i) begin
					next_rdata = mem_rdata_i;
					next_state = SDT_DONE;
				end
			end
			SDT_DONE: begin
				next_state = SDT_IDLE;
			end
			default: begin
				next_state = SDT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state   <= SDT_IDLE;
			ins     <= 32'h0000_0000;
			addr    <= 32'h0000_0000;
			modaddr <= 32'h0000_0000;
			src     <= 32'h0000_0000;
			rdata   <= 32'h0000_0000;
			skip    <= 1'b0;
		end else begin
			state   <= next_state;
			ins     <= next_ins;
			addr    <= next_addr;
			modaddr <= next_modaddr;
			src     <= next_src;
			rdata   <= next_rdata;
			skip    <= next_skip;
		end
	end

	// ==========================================================
	// memory side and register bank outputs
	assign mem_req_o   = (state == SDT_MEM);
	assign mem_addr_o  = addr;
	assign mem_we_o    = !ins[`SDT_F_L];
	assign mem_byte_o  = ins[`SDT_F_B];
	// lets the mmu treat an os-issued access as user
	assign mem_user_o  = !ins[`SDT_F_P] && ins[`SDT_F_W];
	assign mem_wdata_o = lane_store;

	always_comb begin
		rd_we_o     = (state == SDT_DONE) && ins[`SDT_F_L];
		rd_idx_o    = ins[`SDT_F_RD_HI:`SDT_F_RD_LO];
		rd_data_o   = lane_load;
		// post-index always writes back; pre-index only with w set
		base_we_o   = (state == SDT_DONE) && (!ins[`SDT_F_P] || ins[`SDT_F_W]);
		base_idx_o  = ins[`SDT_F_RN_HI:`SDT_F_RN_LO];
		base_data_o = modaddr;
		skip_o      = skip;
	end

	// ==========================================================
	// wishbone slave: one wait state, unmapped reads zero and writes are dropped
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_comb begin
		next_ctrl      = ctrl;
		next_done_cnt  = done_cnt;
		next_skip_cnt  = skip_cnt;
		next_last_addr = last_addr;
		next_wb_ack    = wb_hit;
		next_wb_dat    = 32'h0000_0000;
		if (state == SDT_DONE) begin
			next_done_cnt  = done_cnt + 32'h0000_0001;
			next_last_addr = addr;
		end
		if (skip) begin
			next_skip_cnt = skip_cnt + 32'h0000_0001;
		end
		if (wb_hit && wb_we_i && wb_adr_i == `SDT_OFS_CTRL && wb_sel_i[0]) begin
			next_ctrl = {31'h0000_0000, wb_dat_i[`SDT_CTRL_EN_BIT]};
		end
		if (wb_hit && !wb_we_i) begin
			case (wb_adr_i)
				`SDT_OFS_CTRL:      next_wb_dat = ctrl;
				`SDT_OFS_STATUS:    next_wb_dat = {30'h0000_0000, mem_req_o, state != SDT_IDLE};
				`SDT_OFS_DONE_CNT:  next_wb_dat = done_cnt;
				`SDT_OFS_SKIP_CNT:  next_wb_dat = skip_cnt;
				`SDT_OFS_LAST_ADDR: next_wb_dat = last_addr;
				default:            next_wb_dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl      <= `SDT_CTRL_RESET;
			done_cnt  <= 32'h0000_0000;
			skip_cnt  <= 32'h0000_0000;
			last_addr <= 32'h0000_0000;
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
		end else begin
			ctrl      <= next_ctrl;
			done_cnt  <= next_done_cnt;
			skip_cnt  <= next_skip_cnt;
			last_addr <= next_last_addr;
			wb_ack_o  <= next_wb_ack;
			wb_dat_o  <= next_wb_dat;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_cond_skip;
		take && !cond_pass(instr_i[31:28], flags_i) |=> skip_o && !mem_req_o ##1 !rd_we_o && !base_we_o;
	endproperty
	a_cond_skip: assert property (p_cond_skip) else $error("failed condition still transferred");

	property p_pre_addr;
		take && cond_pass(instr_i[31:28], flags_i) && instr_i[24] && !instr_i[25]
			|=> mem_addr_o == (ins[23] ? $past(base_register_i) + {20'h0_0000, ins[11:0]}
				: $past(base_register_i) - {20'h0_0000, ins[11:0]});
	endproperty
	a_pre_addr: assert property (p_pre_addr) else $error("pre-index address wrong");

	property p_post_addr;
		take && cond_pass(instr_i[31:28], flags_i) && !instr_i[24] |=> mem_addr_o == $past(base_register_i);
	endproperty
	a_post_addr: assert property (p_post_addr) else $error("post-index used modified address");

	property p_pre_wb;
		mem_req_o && mem_ack_i && ins[24] |=> base_we_o == ins[21]
			&& (!base_we_o || base_data_o == mem_addr_o);
	endproperty
	a_pre_wb: assert property (p_pre_wb) else $error("pre-index write-back without w");

	property p_post_wb;
		mem_req_o && mem_ack_i && !ins[24] |=> base_we_o && (ins[25] || base_data_o
			== (ins[23] ? mem_addr_o + {20'h0_0000, ins[11:0]}
				: mem_addr_o - {20'h0_0000, ins[11:0]}));
	endproperty
	a_post_wb: assert property (p_post_wb) else $error("post-index missed write-back");

	property p_user;
		mem_req_o |-> mem_user_o == (!ins[24] && ins[21]);
	endproperty
	a_user: assert property (p_user) else $error("user marking wrong");

	property p_byte_store;
		mem_req_o && mem_we_o && mem_byte_o |-> mem_wdata_o == {4{src[7:0]}};
	endproperty
	a_byte_store: assert property (p_byte_store) else $error("byte store not replicated");

	property p_word_store;
		mem_req_o && mem_we_o && !mem_byte_o |-> mem_wdata_o == src;
	endproperty
	a_word_store: assert property (p_word_store) else $error("word store altered");

	property p_byte_load;
		mem_req_o && mem_ack_i && mem_byte_o && !mem_we_o |=> rd_we_o && rd_data_o[31:8] == 24'h00_0000
			&& rd_data_o[7:0] == 8'($past(mem_rdata_i) >> (endianness_select_i
				? 8*(3-addr[1:0]) : 8*addr[1:0]));
	endproperty
	a_byte_load: assert property (p_byte_load) else $error("byte load lane wrong");

	property p_word_load;
		rd_we_o && !ins[22] && !endianness_select_i
			|-> rd_data_o[7:0] == 8'($past(mem_rdata_i) >> (8*addr[1:0]));
	endproperty
	a_word_load: assert property (p_word_load) else $error("word load not rotated");

	c_byte_load:  cover property (rd_we_o && ins[22]);
	c_post_user:  cover property (mem_req_o && mem_user_o ##[1:20] base_we_o);
	c_skip:       cover property (skip_o);
	c_word_store: cover property (mem_req_o && mem_we_o && !mem_byte_o && addr[1:0] != 2'b00);

endmodule

// ===== sdt_mem_model.sv
// memory partner model on the transfer unit data bus
module sdt_mem_model (
	input  wire logic        clk_i,    // core clock
	input  wire logic        arst_n_i, // async reset, active low
	input  wire logic        req_i,    // transfer request
	input  wire logic [31:0] addr_i,   // transfer address
	input  wire logic        we_i,     // store
	input  wire logic        byte_i,   // byte transfer
	input  wire logic        big_i,    // big-endian lane order
	input  wire logic [31:0] wdata_i,  // store data
	input  wire logic [3:0]  dly_i,    // wait cycles before ack
	output logic      [31:0] rdata_o,  // load data
	output logic             ack_o     // transfer done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16];
	logic [3:0]  cnt;
	logic [1:0]  lane;
	assign lane = big_i ? ~addr_i[1:0] : addr_i[1:0];
	// released bus shows the inverse so stale data never passes
	assign rdata_o = ack_o ? mem[addr_i[5:2]] : ~mem[addr_i[5:2]];
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_o <= 1'b0;
			cnt <= 4'h0;
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 32'h0;
			end
		end else begin
			ack_o <= req_i && !ack_o && cnt == dly_i;
			cnt <= (req_i && !ack_o && cnt != dly_i) ? cnt + 4'h1 : 4'h0;
			if (req_i && ack_o && we_i && byte_i) begin
				mem[addr_i[5:2]][8*lane +: 8] <= wdata_i[8*lane +: 8];
			end else if (req_i && ack_o && we_i) begin
				mem[addr_i[5:2]] <= wdata_i;
			end
		end
	end
endmodule

// ===== single_data_transfer_unit_test.sv
// self-checking testbench for the single data transfer unit
module single_data_transfer_unit_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, iv = 1'b0;
	logic        big = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, ins = 32'h0, basev = 32'h0, offv = 32'h0, srcv = 32'h0;
	logic [3:0]  flg = 4'h0, mdly = 4'h0;
	logic [31:0] wb_rdat, maddr, mwdata, mrdata, rdd, bdd;
	logic        ack, rdy, mreq, mwe, mbyte, muser, mack, rdwe, bwe, skip;
	logic [31:0] c_addr, c_wdata, c_rd, c_base;
	logic        c_we, c_byte, c_user, c_rdwe, c_bwe, c_skip, c_req;
	logic [3:0]  rdi, bdi, c_ri, c_bi;
	int          mismatches = 0, comparisons = 0, ndone = 0, nskip = 0;
	always #2 clk = ~clk;
	sdt_core dut (.clk_i(clk), .arst_n_i(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(ack), .instr_valid_i(iv), .instr_ready_o(rdy),
		.instr_i(ins), .flags_i(flg), .base_register_i(basev), .offset_reg_i(offv),
		.src_reg_i(srcv), .endianness_select_i(big), .mem_req_o(mreq), .mem_addr_o(maddr),
		.mem_we_o(mwe), .mem_byte_o(mbyte), .mem_user_o(muser), .mem_wdata_o(mwdata),
		.mem_rdata_i(mrdata), .mem_ack_i(mack), .rd_we_o(rdwe), .rd_idx_o(rdi),
		.rd_data_o(rdd), .base_we_o(bwe), .base_idx_o(bdi), .base_data_o(bdd), .skip_o(skip));
	sdt_mem_model mem (.clk_i(clk), .arst_n_i(arst_n), .req_i(mreq), .addr_i(maddr),
		.we_i(mwe), .byte_i(mbyte), .big_i(big), .wdata_i(mwdata), .dly_i(mdly),
		.rdata_o(mrdata), .ack_o(mack));
	// ==========================================================
	// checking and closing
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic hung;
		mismatches++;
		test_done();
	endtask
	// ==========================================================
	// access tasks
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) hung();
		q = wb_rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	function automatic logic [31:0] enc(input logic [3:0] c, input logic [5:0] m,
		input logic [11:0] lo);
		return {c, 2'b01, m, 4'h1, 4'h2, lo};
	endfunction
	task automatic exe(input logic [31:0] i, input logic [31:0] b, input logic [31:0] o,
		input logic [31:0] s, input logic [3:0] f);
		int n;
		@(posedge clk);
		iv <= 1'b1;
		ins <= i;
		basev <= b;
		offv <= o;
		srcv <= s;
		flg <= f;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) hung();
		iv <= 1'b0;
		{c_req, c_rdwe, c_bwe, c_skip} = 4'h0;
		// sample after the edge so the unit's updates have landed
		for (n = 0; n < 40; n++) begin
			#1;
			if (mreq) {c_req, c_addr, c_we, c_byte, c_user, c_wdata} = {1'b1, maddr, mwe,
				mbyte, muser, mwdata};
			if (rdwe) {c_rdwe, c_rd, c_ri} = {1'b1, rdd, rdi};
			if (bwe) {c_bwe, c_base, c_bi} = {1'b1, bdd, bdi};
			if (skip) c_skip = 1'b1;
			if (rdy === 1'b1) break;
			@(posedge clk);
		end
		if (n >= 40) hung();
	endtask
	task automatic xfer(input logic [31:0] a, input logic w, input logic bt, input logic u,
		input logic [31:0] d, input logic bw, input logic [31:0] bd);
		chk("address", c_addr, a);
		chk("direction", c_we, w);
		chk("size", c_byte, bt);
		chk("user access", c_user, u);
		if (w) chk("store data", c_wdata, d);
		else chk("load data", c_rd, d);
		chk("load pulse", c_rdwe, !w);
		chk("base write", c_bwe, bw);
		if (bw) chk("base value", c_base, bd);
		if (!w) chk("dest index", c_ri, 4'h2);
		if (bw) chk("base index", c_bi, 4'h1);
		ndone++;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] q;
		logic [31:0] shx [4] = '{32'h2000, 32'h08001010, 32'hf8001010, 32'h08001010};
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		wb(1'b0, 8'h00, 32'h0, q);
		chk("ctrl reset", q, 32'h1);
		wb(1'b0, 8'h20, 32'h0, q);
		chk("unmapped read", q, 32'h0);
		exe(enc(4'he, 6'b011010, 12'h006), 32'h100, 32'h0, 32'h11223344, 4'h0);
		xfer(32'h106, 1'b1, 1'b0, 1'b0, 32'h11223344, 1'b1, 32'h106);
		mdly <= 4'h5;
		exe(enc(4'he, 6'b000001, 12'h010), 32'h106, 32'h0, 32'h0, 4'h0);
		xfer(32'h106, 1'b0, 1'b0, 1'b0, 32'h33441122, 1'b1, 32'h0f6);
		mdly <= 4'h0;
		exe(enc(4'he, 6'b011000, 12'h200), 32'h0, 32'h0, 32'h44332211, 4'h0);
		xfer(32'h200, 1'b1, 1'b0, 1'b0, 32'h44332211, 1'b0, 32'h0);
		for (int e = 0; e < 2; e++) begin
			for (int k = 0; k < 4; k++) begin
				@(posedge clk);
				big <= e[0];
				exe(enc(4'he, 6'b111101, 12'h000), 32'h200, k, 32'h0, 4'h0);
				q = (32'h44332211 >> (8 * (e ? 3 - k : k))) & 32'hff;
				xfer(32'h200 + k, 1'b0, 1'b1, 1'b0, q, 1'b0, 32'h0);
			end
		end
		@(posedge clk);
		big <= 1'b0;
		exe(enc(4'he, 6'b001110, 12'h001), 32'h201, 32'h0, 32'hcafe005a, 4'h0);
		xfer(32'h201, 1'b1, 1'b1, 1'b1, 32'h5a5a5a5a, 1'b1, 32'h202);
		exe(enc(4'he, 6'b011001, 12'h000), 32'h200, 32'h0, 32'h0, 4'h0);
		xfer(32'h200, 1'b0, 1'b0, 1'b0, 32'h44335a11, 1'b0, 32'h0);
		// immediate shift amount 4, each shift type
		for (int t = 0; t < 4; t++) begin
			exe(enc(4'he, 6'b111000, {5'd4, t[1:0], 5'h00}), 32'h1000, 32'h80000100, 32'h0, 4'h0);
			xfer(shx[t], 1'b1, 1'b0, 1'b0, 32'h0, 1'b0, 32'h0);
		end
		exe(enc(4'h0, 6'b011010, 12'h004), 32'h300, 32'h0, 32'h1, 4'h0);
		chk("skip pulse", c_skip, 1'b1);
		chk("no request", c_req, 1'b0);
		chk("no base write", c_bwe, 1'b0);
		nskip++;
		exe(enc(4'he, 6'b011010, 12'h004), 32'h300, 32'h0, 32'h1, 4'h0);
		exe(enc(4'h0, 6'b011010, 12'h004), 32'h300, 32'h0, 32'h1, 4'h4);
		xfer(32'h304, 1'b1, 1'b0, 1'b0, 32'h1, 1'b1, 32'h304);
		ndone++;
		wb(1'b0, 8'h08, 32'h0, q);
		chk("done count", q, ndone);
		wb(1'b0, 8'h0c, 32'h0, q);
		chk("skip count", q, nskip);
		wb(1'b0, 8'h04, 32'h0, q);
		chk("status idle", q, 32'h0);
		wb(1'b1, 8'h00, 32'h0, q);
		#1;
		chk("ready while disabled", rdy, 1'b0);
		wb(1'b1, 8'h00, 32'h1, q);
		#1;
		chk("ready enabled", rdy, 1'b1);
		test_done();
	end
endmodule
